/* File: mac_periph.sv */
// multiply-accumulate peripheral with word registers on the peripheral bus
module mac_periph
  import mac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // peripheral register bus
  input wire logic bus_sel,
  input wire logic bus_we,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata
);
  logic [15:0] op1_q, op1_d;
  logic [15:0] op2_q, op2_d;
  mode_e mode_q, mode_d;
  result_s res_q, res_d;
  logic [15:0] rdata_q, rdata_d;
  logic signed [32:0] sprod;
  logic [31:0] uprod;
  logic [31:0] prod;
  logic [32:0] usum;
  logic [31:0] acc;
  logic wr, rd;

  assign wr = bus_sel && bus_we;
  assign rd = bus_sel && !bus_we;

  always_comb begin
    uprod = op1_q * bus_wdata;
    sprod = 33'($signed(op1_q) * $signed(bus_wdata));
    // accumulators use the fresh product so results sit ready one cycle later
    acc = {res_q.result_high, res_q.result_low};
    usum = {1'b0, acc} + {1'b0, uprod}; // [RQ15]
  end

  // operand, mode and result state; operands are not reset, they persist
  always_comb begin
    op1_d = op1_q;
    op2_d = op2_q;
    mode_d = mode_q;
    res_d = res_q;
    prod = 32'h0000_0000;
    if (wr) begin
      if (bus_addr == ADDR_OP1_UPROD) begin
        op1_d = bus_wdata; // [RQ14]
        mode_d = unsigned_product_mode; // [RQ11]
      end else if (bus_addr == ADDR_OP1_SPROD) begin
        op1_d = bus_wdata;
        mode_d = signed_product_mode; // [RQ11]
      end else if (bus_addr == ADDR_OP1_UACC) begin
        op1_d = bus_wdata;
        mode_d = unsigned_accumulate_mode; // [RQ11]
      end else if (bus_addr == ADDR_OP1_SACC) begin
        op1_d = bus_wdata;
        mode_d = signed_accumulate_mode; // [RQ11]
      end else if (bus_addr == ADDR_OP2) begin
        op2_d = bus_wdata;
        case (mode_q) // [RQ12]
          unsigned_product_mode: begin
            res_d.result_low = uprod[15:0]; // [RQ1]
            res_d.result_high = uprod[31:16]; // [RQ2]
            res_d.sum_extension = EXT_ZERO; // [RQ2]
          end
          signed_product_mode: begin
            res_d.result_low = sprod[15:0]; // [RQ1]
            res_d.result_high = sprod[31:16]; // [RQ3]
            res_d.sum_extension = sprod[32] ? EXT_NEG : EXT_ZERO; // [RQ4]
          end
          unsigned_accumulate_mode: begin
            res_d.result_low = usum[15:0]; // [RQ1] [RQ15]
            res_d.result_high = usum[31:16];
            res_d.sum_extension = usum[32] ? EXT_CARRY : EXT_ZERO; // [RQ5]
          end
          default: begin
            prod = acc + sprod[31:0]; // [RQ15]
            res_d.result_low = prod[15:0]; // [RQ1]
            res_d.result_high = prod[31:16]; // [RQ6]
            // true sign is from the wide sum, so overflow still reads right [RQ7] [RQ8]
            res_d.sum_extension =
              ($signed({acc[31], acc}) + sprod) < 0 ? EXT_NEG : EXT_ZERO; // [RQ4]
          end
        endcase
      end else if (bus_addr == ADDR_RES_LO) begin
        res_d.result_low = bus_wdata;
      end else if (bus_addr == ADDR_RES_HI) begin
        res_d.result_high = bus_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    op1_q <= op1_d;
    op2_q <= op2_d;
    mode_q <= mode_d;
    res_q <= res_d;
  end

  // read path; unmapped addresses read zero
  always_comb begin
    rdata_d = RDATA_RESET;
    if (rd) begin
      if (bus_addr >= ADDR_OP1_UPROD && bus_addr <= ADDR_OP1_SACC && !bus_addr[0]) begin
        rdata_d = op1_q;
      end else if (bus_addr == ADDR_OP2) begin
        rdata_d = op2_q;
      end else if (bus_addr == ADDR_RES_LO) begin
        rdata_d = res_q.result_low; // [RQ13]
      end else if (bus_addr == ADDR_RES_HI) begin
        rdata_d = res_q.result_high;
      end else if (bus_addr == ADDR_SUM_EXT) begin
        rdata_d = res_q.sum_extension;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_q <= RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;

  a_uprod_ext: assert property (@(posedge clk) disable iff (!resetn) // [RQ2]
    (wr && bus_addr == ADDR_OP2 && mode_q == unsigned_product_mode)
      |=> res_q.sum_extension == EXT_ZERO)
    else $error("unsigned product extension not zero");
  a_low_word: assert property (@(posedge clk) disable iff (!resetn) // [RQ1]
    (wr && bus_addr == ADDR_OP2 && mode_q == unsigned_product_mode)
      |=> res_q.result_low == 16'($past(op1_q) * $past(bus_wdata)))
    else $error("low word wrong");
  a_sprod_sign: assert property (@(posedge clk) disable iff (!resetn) // [RQ4]
    (wr && bus_addr == ADDR_OP2 && mode_q == signed_product_mode)
      |=> res_q.sum_extension == {16{res_q.result_high[15]}})
    else $error("signed extension mismatch");
  a_op1_nostart: assert property (@(posedge clk) disable iff (!resetn) // [RQ14]
    (wr && bus_addr == ADDR_OP1_UACC) |=> $stable(res_q))
    else $error("operand one write changed result");
  a_mode_latch: assert property (@(posedge clk) disable iff (!resetn) // [RQ11]
    (wr && bus_addr == ADDR_OP1_SACC) |=> mode_q == signed_accumulate_mode)
    else $error("mode not latched");
  a_uacc_ext: assert property (@(posedge clk) disable iff (!resetn) // [RQ5]
    (wr && bus_addr == ADDR_OP2 && mode_q == unsigned_accumulate_mode)
      |=> res_q.sum_extension[15:1] == 15'h0000)
    else $error("carry extension out of range");
  a_read_next: assert property (@(posedge clk) disable iff (!resetn) // [RQ13]
    (wr && bus_addr == ADDR_OP2) ##1 (rd && bus_addr == ADDR_RES_LO)
      |=> bus_rdata == $past(res_q.result_low))
    else $error("result not readable next access");
  a_op1_keep: assert property (@(posedge clk) disable iff (!resetn) // [RQ12]
    (wr && bus_addr == ADDR_OP2) |=> $stable(op1_q))
    else $error("operand one lost");

  // product modes
  a_uprod_value: assert property (@(posedge clk) disable iff (!resetn) // [RQ2]
    (wr && bus_addr == ADDR_OP2 && mode_q == unsigned_product_mode)
      |=> {res_q.result_high, res_q.result_low} == $past(op1_q) * $past(bus_wdata))
    else $error("unsigned product wrong");

  a_sprod_low: assert property (@(posedge clk) disable iff (!resetn) // [RQ1]
    (wr && bus_addr == ADDR_OP2 && mode_q == signed_product_mode)
      |=> res_q.result_low == 16'($past(op1_q) * $past(bus_wdata)))
    else $error("signed product low word wrong");

  a_sprod_value: assert property (@(posedge clk) disable iff (!resetn) // [RQ3]
    (wr && bus_addr == ADDR_OP2 && mode_q == signed_product_mode)
      |=> $signed({res_q.result_high, res_q.result_low})
        == $signed($past(op1_q)) * $signed($past(bus_wdata)))
    else $error("signed product wrong");

  a_sprod_ext: assert property (@(posedge clk) disable iff (!resetn) // [RQ4]
    (wr && bus_addr == ADDR_OP2 && mode_q == signed_product_mode)
      |=> res_q.sum_extension == (($signed($past(op1_q)) * $signed($past(bus_wdata))) < 0
        ? EXT_NEG : EXT_ZERO))
    else $error("signed product extension wrong");

  // accumulate modes
  a_uacc_low: assert property (@(posedge clk) disable iff (!resetn) // [RQ1]
    (wr && bus_addr == ADDR_OP2 && mode_q == unsigned_accumulate_mode)
      |=> res_q.result_low == 16'($past(res_q.result_low) + $past(op1_q) * $past(bus_wdata)))
    else $error("unsigned accumulate low word wrong");

  a_uacc_value: assert property (@(posedge clk) disable iff (!resetn) // [RQ15]
    (wr && bus_addr == ADDR_OP2 && mode_q == unsigned_accumulate_mode)
      |=> {res_q.result_high, res_q.result_low}
        == 32'({$past(res_q.result_high), $past(res_q.result_low)}
        + $past(op1_q) * $past(bus_wdata)))
    else $error("unsigned accumulate sum wrong");

  a_uacc_carry: assert property (@(posedge clk) disable iff (!resetn) // [RQ5]
    (wr && bus_addr == ADDR_OP2 && mode_q == unsigned_accumulate_mode)
      |=> res_q.sum_extension == ((33'({$past(res_q.result_high), $past(res_q.result_low)})
        + 33'($past(op1_q) * $past(bus_wdata))) > 33'h0FFFFFFFF ? EXT_CARRY : EXT_ZERO))
    else $error("unsigned accumulate carry wrong");

  a_sacc_low: assert property (@(posedge clk) disable iff (!resetn) // [RQ1]
    (wr && bus_addr == ADDR_OP2 && mode_q == signed_accumulate_mode)
      |=> res_q.result_low == 16'($past(res_q.result_low) + $past(op1_q) * $past(bus_wdata)))
    else $error("signed accumulate low word wrong");

  a_sacc_value: assert property (@(posedge clk) disable iff (!resetn) // [RQ6]
    (wr && bus_addr == ADDR_OP2 && mode_q == signed_accumulate_mode)
      |=> {res_q.result_high, res_q.result_low}
        == {$past(res_q.result_high), $past(res_q.result_low)}
        + 32'($signed($past(op1_q)) * $signed($past(bus_wdata))))
    else $error("signed accumulate sum wrong");

  // the wide sum keeps the sign that a 32-bit wrap would lose
  a_sacc_sign: assert property (@(posedge clk) disable iff (!resetn) // [RQ7]
    (wr && bus_addr == ADDR_OP2 && mode_q == signed_accumulate_mode)
      |=> res_q.sum_extension == (($signed({$past(res_q.result_high[15]),
        $past(res_q.result_high), $past(res_q.result_low)}) + 33'($signed($past(op1_q))
        * $signed($past(bus_wdata)))) < 0 ? EXT_NEG : EXT_ZERO))
    else $error("signed accumulate sign wrong");

  // register file
  a_lo_write: assert property (@(posedge clk) disable iff (!resetn) // [RQ15]
    (wr && bus_addr == ADDR_RES_LO) |=> res_q.result_low == $past(bus_wdata))
    else $error("low word write lost");

  a_hi_write: assert property (@(posedge clk) disable iff (!resetn) // [RQ15]
    (wr && bus_addr == ADDR_RES_HI) |=> res_q.result_high == $past(bus_wdata))
    else $error("high word write lost");

  a_ext_readonly: assert property (@(posedge clk) disable iff (!resetn) // [RQ11]
    (wr && bus_addr == ADDR_SUM_EXT) |=> $stable(res_q.sum_extension))
    else $error("extension word was written");

  a_op1_store: assert property (@(posedge clk) disable iff (!resetn) // [RQ14]
    (wr && bus_addr >= ADDR_OP1_UPROD && bus_addr <= ADDR_OP1_SACC && !bus_addr[0])
      |=> op1_q == $past(bus_wdata))
    else $error("operand one not stored");

  a_op2_store: assert property (@(posedge clk) disable iff (!resetn) // [RQ12]
    (wr && bus_addr == ADDR_OP2) |=> op2_q == $past(bus_wdata))
    else $error("operand two not stored");

  a_op2_mode: assert property (@(posedge clk) disable iff (!resetn) // [RQ12]
    (wr && bus_addr == ADDR_OP2) |=> $stable(mode_q))
    else $error("operand two write changed mode");

  a_mode_uprod: assert property (@(posedge clk) disable iff (!resetn) // [RQ11]
    (wr && bus_addr == ADDR_OP1_UPROD) |=> mode_q == unsigned_product_mode)
    else $error("unsigned product mode not latched");

  a_mode_sprod: assert property (@(posedge clk) disable iff (!resetn) // [RQ11]
    (wr && bus_addr == ADDR_OP1_SPROD) |=> mode_q == signed_product_mode)
    else $error("signed product mode not latched");

  a_mode_uacc: assert property (@(posedge clk) disable iff (!resetn) // [RQ11]
    (wr && bus_addr == ADDR_OP1_UACC) |=> mode_q == unsigned_accumulate_mode)
    else $error("unsigned accumulate mode not latched");

  // read path
  a_read_hi: assert property (@(posedge clk) disable iff (!resetn) // [RQ13]
    (rd && bus_addr == ADDR_RES_HI) |=> bus_rdata == $past(res_q.result_high))
    else $error("high word read wrong");

  a_read_ext: assert property (@(posedge clk) disable iff (!resetn) // [RQ13]
    (rd && bus_addr == ADDR_SUM_EXT) |=> bus_rdata == $past(res_q.sum_extension))
    else $error("extension word read wrong");

  a_read_op1: assert property (@(posedge clk) disable iff (!resetn) // [RQ11]
    (rd && bus_addr == ADDR_OP1_UACC) |=> bus_rdata == $past(op1_q))
    else $error("operand one read wrong");

  a_read_op2: assert property (@(posedge clk) disable iff (!resetn) // [RQ12]
    (rd && bus_addr == ADDR_OP2) |=> bus_rdata == $past(op2_q))
    else $error("operand two read wrong");

  // read data stands one cycle only, so a stale word never looks fresh
  a_read_idle: assert property (@(posedge clk) disable iff (!resetn) // [RQ13]
    !rd |=> bus_rdata == RDATA_RESET)
    else $error("read data held past its cycle");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!resetn) // [RQ11]
    (rd && (bus_addr < ADDR_OP1_UPROD || bus_addr > ADDR_SUM_EXT))
      |=> bus_rdata == RDATA_RESET)
    else $error("unmapped read not zero");

  a_reset_rdata: assert property (@(posedge clk) // [RQ13]
    !resetn |=> bus_rdata == RDATA_RESET)
    else $error("read data not cleared in reset");

  c_uprod: cover property (@(posedge clk) wr && bus_addr == ADDR_OP2
    && mode_q == unsigned_product_mode);
  c_read_after: cover property (@(posedge clk) (wr && bus_addr == ADDR_OP2)
    ##1 (rd && bus_addr == ADDR_RES_LO));
  c_sacc: cover property (@(posedge clk) wr && bus_addr == ADDR_OP2
    && mode_q == signed_accumulate_mode);
  c_uacc_carry: cover property (@(posedge clk) wr && bus_addr == ADDR_OP2
    && mode_q == unsigned_accumulate_mode && usum[32]);
  c_sprod: cover property (@(posedge clk) wr && bus_addr == ADDR_OP2
    && mode_q == signed_product_mode);
endmodule

/* File: mac_pkg.sv */
// constants and types for the memory-mapped multiply-accumulate peripheral
// Overview of operation
// RQ1: result low word always holds the lower 16 bits of the result.
// RQ2: unsigned product: high word gets upper 16 bits, extension word is 0000h.
// RQ3: signed product: two's complement result, high word top bit is the sign.
// RQ4: signed modes: extension word is FFFFh when negative, 0000h when positive.
// RQ5: unsigned accumulate: extension word is 0001h on carry, else 0000h.
// RQ6: signed accumulate: high word keeps upper 16 accumulated bits, two's complement.
// RQ7: no overflow flag; extension word still shows the true sign.
// RQ8: 32-bit values from 8000_0000h upward count as negative in signed accumulation.
// RQ9: software leaves one instruction before indirect result reads.
// RQ10: software keeps the multiplier out of interrupt handlers mid-sequence.
// RQ11: operand-one addresses 0130h to 0136h pick the mode; operand two at 0138h.
// RQ12: writing operand two starts the operation with the stored operand one.
// RQ13: results are valid for the instruction right after the operand-two write.
// RQ14: an operand-one write only stores the operand and the mode.
// RQ15: accumulate modes add the product to the prior result and write back.
package mac_pkg;
  localparam logic [15:0] ADDR_OP1_UPROD = 16'h0130;
  localparam logic [15:0] ADDR_OP1_SPROD = 16'h0132;
  localparam logic [15:0] ADDR_OP1_UACC = 16'h0134;
  localparam logic [15:0] ADDR_OP1_SACC = 16'h0136;
  localparam logic [15:0] ADDR_OP2 = 16'h0138;
  localparam logic [15:0] ADDR_RES_LO = 16'h013A;
  localparam logic [15:0] ADDR_RES_HI = 16'h013C;
  localparam logic [15:0] ADDR_SUM_EXT = 16'h013E;
  localparam logic [15:0] EXT_NEG = 16'hFFFF;
  localparam logic [15:0] EXT_ZERO = 16'h0000;
  localparam logic [15:0] EXT_CARRY = 16'h0001;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    unsigned_product_mode,
    signed_product_mode,
    unsigned_accumulate_mode,
    signed_accumulate_mode
  } mode_e;

  typedef struct packed {
    logic [15:0] result_low;
    logic [15:0] result_high;
    logic [15:0] sum_extension;
  } result_s;
endpackage

/* File: core_model.sv */
// processor core model that drives the multiplier's register bus
module core_model (
  // clock
  input wire logic clk,
  // register bus
  output logic bus_sel,
  output logic bus_we,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_sel = 1'b0;
    bus_we = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 16'h0000;
  end
  // one word access per cycle, strobe kept high between back-to-back calls;
  // result reads use direct addresses only, so no spacing is needed
  // op1 and op2 writes are split by no traffic other than result reads and earlier op2 writes
  task automatic access(input logic we, input logic [15:0] a, d, output logic [15:0] q);
    bus_sel = 1'b1;
    bus_we = we;
    bus_addr = a;
    bus_wdata = d;
    @(negedge clk);
    q = bus_rdata;
  endtask
  // released address and data lines show the inverse, not the stale value; bus_we keeps its value
  task automatic idle;
    bus_sel = 1'b0;
    bus_addr = ~bus_addr;
    bus_wdata = ~bus_wdata;
    @(negedge clk);
  endtask
endmodule

/* File: test_mac_periph.sv */
// self-checking bench for the multiply-accumulate peripheral
module test_mac_periph import mac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, bus_sel, bus_we;
  logic [15:0] bus_addr, bus_wdata, bus_rdata, q;
  logic [31:0] acc;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  mac_periph dut (.clk(clk), .resetn(resetn), .bus_sel(bus_sel), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
  core_model cpu (.clk(clk), .bus_sel(bus_sel), .bus_we(bus_we), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic stop_test;
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // acc mirrors high:low; signed sums use 33 bits so the true sign survives overflow
  task automatic op(input logic [1:0] m, input logic [15:0] a, b, input bit load);
    logic [32:0] s;
    if (load) cpu.access(1'b1, ADDR_OP1_UPROD + 16'(2 * m), a, q);
    cpu.access(1'b1, ADDR_OP2, b, q);
    s = m[0] ? 33'($signed(a) * $signed(b)) : 33'(a * b);
    if (m[1]) s = s + (m[0] ? {acc[31], acc} : {1'b0, acc});
    acc = s[31:0];
    cpu.access(1'b0, ADDR_RES_LO, 16'h0000, q);
    check("result low", acc[15:0], q);
    cpu.access(1'b0, ADDR_RES_HI, 16'h0000, q);
    check("result high", acc[31:16], q);
    cpu.access(1'b0, ADDR_SUM_EXT, 16'h0000, q);
    check("sum extension", m[0] ? {16{s[32]}} : {15'h0000, s[32] & m[1]}, q);
  endtask
  task automatic set_acc(input logic [31:0] v);
    cpu.access(1'b1, ADDR_RES_LO, v[15:0], q);
    cpu.access(1'b1, ADDR_RES_HI, v[31:16], q);
    acc = v;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    resetn = 1'b0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check("rdata after reset", RDATA_RESET, bus_rdata);
    for (int m = 0; m < 4; m++) op(2'(m), 16'hFF85, 16'h7FF3, 1'b1);
    op(2'd3, 16'hFF85, 16'h0003, 1'b0);
    set_acc(32'hFFFF_FFFF);
    op(2'd2, 16'h0001, 16'h0001, 1'b1);
    set_acc(32'h8000_0000);
    op(2'd3, 16'hFFFF, 16'h0001, 1'b1);
    set_acc(32'h7FFF_FFFF);
    op(2'd3, 16'h0001, 16'h0001, 1'b1);
    cpu.access(1'b1, ADDR_OP1_SPROD, 16'h0005, q);
    cpu.access(1'b0, ADDR_RES_LO, 16'h0000, q);
    check("low after op1 write", acc[15:0], q);
    cpu.access(1'b0, ADDR_OP1_UACC, 16'h0000, q);
    check("op1 readback", 16'h0005, q);
    cpu.access(1'b1, ADDR_SUM_EXT, 16'h1234, q);
    cpu.access(1'b0, ADDR_SUM_EXT, 16'h0000, q);
    check("extension read-only", EXT_ZERO, q);
    cpu.access(1'b0, 16'h0140, 16'h0000, q);
    check("unmapped read", 16'h0000, q);
    cpu.idle();
    check("rdata when idle", RDATA_RESET, bus_rdata);
    stop_test();
  end
endmodule
